/* src/gso_status_out.sv */
// GPIO status output selector: register file, speaker protection,
// interrupt status, analogue switch control and pin selection.
// Assumes all inputs synchronous to sys_clk and a strobe-style register
// port with read data one cycle after the read strobe.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gso_defines.svh"
// Notes on behaviour
// - two PWM waves selectable per pin
// - PWM duty from audio or fixed register
// - S/PDIF on pin, software validity and status
// - lock flag per rate converter, pin selectable
// - lock flags raise events on both edges
// - event bits sticky, pollable, drive interrupt
// - thermal, short, shutdown flags pin selectable
// - overheat or short disables speaker outputs
// - shutdown flag only after driver stop completes
// - timer watchdog expiry shuts speaker down
// - protection flags raise events on rising edges
// - timers up/down, modes, progress pin output
// - timer pin pulses at final count
// - timer final count raises event
// - sixteen-entry logger FIFO status per pin
// - logger pin high while FIFO not empty
// - logger FIFO condition raises event
// - switch mode open, closed, clamp-gated
module gso_status_out #(
	parameter int NUM_PINS = 40 // General purpose pins served
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic [1:0] pwm_wave,
	input wire logic spdif_tx,
	input wire logic [3:0] asrc_lock,
	input wire logic temp_warn,
	input wire logic temp_shutdown,
	input wire logic [1:0] spk_short,
	input wire logic spk_off_done,
	input wire logic [7:0] timer_final,
	input wire logic [7:0] fifo_not_empty,
	input wire logic accessory_detect,
	output logic [NUM_PINS-1:0] gpio_out,
	output logic [NUM_PINS-1:0] gpio_src_valid,
	output logic irq,
	output logic spk_disable,
	output logic switch_close,
	output logic [1:0] pwm_duty_sel,
	output logic [15:0] pwm0_duty,
	output logic [15:0] pwm1_duty,
	output logic [1:0] spdif_validity,
	output logic [31:0] spdif_chan_status
);
	import gso_pkg::*;

	// Shared flag levels and their events
	gso_evt_if ev ();

	// Register state
	logic [`GSO_FN_W-1:0] fn_code [NUM_PINS]; // Per-pin function code
	logic [NUM_PINS*`GSO_FN_W-1:0] fn_flat; // Codes packed for the mux
	gso_sw_mode_e sw_mode; // Analogue switch mode
	logic wd_en; // Watchdog enable
	logic [2:0] wd_sel; // Timer used as watchdog
	logic [`GSO_EV_W-1:0] status; // Sticky event bits
	logic [`GSO_EV_W-1:0] mask; // Interrupt enables
	gso_spk_state_e spk_state; // Speaker protection state
	gso_spk_state_e next_spk_state; // Its next value

	// Address decode
	wire [15:0] fn_off = reg_addr - `GSO_REG_FN_BASE;
	wire fn_hit = fn_off < 16'(NUM_PINS);
	wire wr_sw = reg_wr && reg_addr == `GSO_REG_SWITCH;
	wire wr_pwm = reg_wr && reg_addr == `GSO_REG_PWM_CTRL;
	wire wr_d0 = reg_wr && reg_addr == `GSO_REG_PWM0_DUTY;
	wire wr_d1 = reg_wr && reg_addr == `GSO_REG_PWM1_DUTY;
	wire wr_sc = reg_wr && reg_addr == `GSO_REG_SPDIF_CTRL;
	wire wr_cl = reg_wr && reg_addr == `GSO_REG_SPDIF_CS_LO;
	wire wr_ch = reg_wr && reg_addr == `GSO_REG_SPDIF_CS_HI;
	wire wr_spk = reg_wr && reg_addr == `GSO_REG_SPK_CTRL;
	wire wr_sa = reg_wr && reg_addr == `GSO_REG_STAT_A;
	wire wr_sb = reg_wr && reg_addr == `GSO_REG_STAT_B;
	wire wr_ma = reg_wr && reg_addr == `GSO_REG_MASK_A;
	wire wr_mb = reg_wr && reg_addr == `GSO_REG_MASK_B;
	// Restart is a self-clearing command bit
	wire restart = wr_spk && reg_wdata[`GSO_SPK_RESTART];

	// Function code registers, one per pin
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_fn
		// Write when the offset names this pin
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) fn_code[i] <= '0;
			else if (reg_wr && fn_hit && fn_off == 16'(i))
				fn_code[i] <= reg_wdata[`GSO_FN_W-1:0];
		end
		assign fn_flat[i*`GSO_FN_W +: `GSO_FN_W] = fn_code[i];
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) sw_mode <= GSO_SW_OPEN;
		else if (wr_sw) sw_mode <= gso_sw_mode_e'(reg_wdata[`GSO_SW_MODE]);
	end

	// duty source select and fixed duties
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwm_duty_sel <= '0;
			pwm0_duty <= '0;
			pwm1_duty <= '0;
		end else begin
			if (wr_pwm) pwm_duty_sel <= reg_wdata[`GSO_PWM_SRC];
			if (wr_d0) pwm0_duty <= reg_wdata;
			if (wr_d1) pwm1_duty <= reg_wdata;
		end
	end

	// software validity bits and channel status
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			spdif_validity <= '0;
			spdif_chan_status <= '0;
		end else begin
			if (wr_sc) spdif_validity <= reg_wdata[`GSO_VALID];
			if (wr_cl) spdif_chan_status[15:0] <= reg_wdata;
			if (wr_ch) spdif_chan_status[31:16] <= reg_wdata;
		end
	end

	// Watchdog configuration
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_en <= 1'b0;
			wd_sel <= '0;
		end else if (wr_spk) begin
			wd_en <= reg_wdata[`GSO_SPK_WD_EN];
			wd_sel <= reg_wdata[`GSO_SPK_WD_SEL];
		end
	end

	// Speaker protection causes
	wire hard_fault = temp_shutdown || (|spk_short);
	wire wd_trip = wd_en && timer_final[wd_sel];
	wire trip = hard_fault || wd_trip;

	// Speaker shutdown sequencing
	always_comb begin
		next_spk_state = spk_state;
		case (spk_state)
			GSO_SPK_RUN: begin
				if (trip) next_spk_state = GSO_SPK_STOP;
			end
			// wait for the driver to finish
			GSO_SPK_STOP: begin
				if (spk_off_done) next_spk_state = GSO_SPK_OFF;
			end
			// Release only with faults gone
			GSO_SPK_OFF: begin
				if (restart && !hard_fault) next_spk_state = GSO_SPK_RUN;
			end
			default: next_spk_state = GSO_SPK_STOP;
		endcase
	end

	// State and speaker disable output
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			spk_state <= GSO_SPK_RUN;
			spk_disable <= 1'b0;
		end else begin
			spk_state <= next_spk_state;
			spk_disable <= next_spk_state != GSO_SPK_RUN;
		end
	end

	// Shutdown complete flag
	wire spk_flag = spk_state == GSO_SPK_OFF;

	// flag levels gathered in event layout
	// protection flags join the same vector
	// timer progress and FIFO status too
	assign ev.level = {fifo_not_empty, timer_final, spk_flag, spk_short,
		temp_shutdown, temp_warn, asrc_lock};

	// Edge events from flag levels
	gso_edge_events u_edges (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.ev(ev.det)
	);

	gso_pin_select #(.NUM_PINS(NUM_PINS)) u_pins (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.fn_flat(fn_flat),
		.pwm_wave(pwm_wave),
		.spdif_tx(spdif_tx),
		.ev(ev.sel),
		.gpio_out(gpio_out),
		.gpio_src_valid(gpio_src_valid)
	);

	// Write-one-to-clear masks for both status words
	wire [`GSO_EVA_W-1:0] clr_a = wr_sa ? reg_wdata[`GSO_EVA_W-1:0] : '0;
	wire [`GSO_EVB_W-1:0] clr_b = wr_sb ? reg_wdata : '0;
	wire [`GSO_EV_W-1:0] next_status = (status & ~{clr_b, clr_a}) | ev.pulse;

	// Sticky status and mask
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			status <= '0;
			mask <= '0;
		end else begin
			status <= next_status;
			if (wr_ma) mask[`GSO_EVA_W-1:0] <= reg_wdata[`GSO_EVA_W-1:0];
			if (wr_mb) mask[`GSO_EV_W-1:`GSO_EVA_W] <= reg_wdata;
		end
	end

	wire irq_any = |(status & mask);

	// switch state from mode and clamp
	wire next_close = (sw_mode == GSO_SW_CLOSED)
		|| (sw_mode == GSO_SW_CLAMP_ON && accessory_detect)
		|| (sw_mode == GSO_SW_CLAMP_OFF && !accessory_detect);

	// Readback selection, unmapped reads zero
	wire [15:0] fn_rd = fn_hit ? 16'(fn_code[fn_off[5:0]]) : '0;
	wire [15:0] rd_mux =
		(reg_addr == `GSO_REG_SWITCH) ? 16'(sw_mode) :
		(reg_addr == `GSO_REG_PWM_CTRL) ? 16'(pwm_duty_sel) :
		(reg_addr == `GSO_REG_PWM0_DUTY) ? pwm0_duty :
		(reg_addr == `GSO_REG_PWM1_DUTY) ? pwm1_duty :
		(reg_addr == `GSO_REG_SPDIF_CTRL) ? 16'(spdif_validity) :
		(reg_addr == `GSO_REG_SPDIF_CS_LO) ? spdif_chan_status[15:0] :
		(reg_addr == `GSO_REG_SPDIF_CS_HI) ? spdif_chan_status[31:16] :
		(reg_addr == `GSO_REG_SPK_CTRL) ? 16'({wd_sel, wd_en}) :
		(reg_addr == `GSO_REG_RAW_A) ? 16'(ev.level[`GSO_EVA_W-1:0]) :
		(reg_addr == `GSO_REG_RAW_B) ? ev.level[`GSO_EV_W-1:`GSO_EVA_W] :
		(reg_addr == `GSO_REG_STAT_A) ? 16'(status[`GSO_EVA_W-1:0]) :
		(reg_addr == `GSO_REG_STAT_B) ? status[`GSO_EV_W-1:`GSO_EVA_W] :
		(reg_addr == `GSO_REG_MASK_A) ? 16'(mask[`GSO_EVA_W-1:0]) :
		(reg_addr == `GSO_REG_MASK_B) ? mask[`GSO_EV_W-1:`GSO_EVA_W] :
		fn_rd;

	// Registered outputs: read data, interrupt, switch
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
			irq <= 1'b0;
			switch_close <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : '0;
			irq <= irq_any;
			switch_close <= next_close;
		end
	end

	// Checks on the block's own outputs
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_event_sets: assert property (
		(|ev.pulse) |=> ((status & $past(ev.pulse)) == $past(ev.pulse)))
		else $error("event did not set its status bit");
	a_sticky_hold: assert property (
		!reg_wr |=> ((status & $past(status)) == $past(status)))
		else $error("status bit dropped without a clear");
	a_irq_follow: assert property (
		irq == $past(irq_any))
		else $error("interrupt did not follow status");
	a_spk_fault_off: assert property (
		hard_fault |=> spk_disable)
		else $error("fault did not disable speaker");
	a_watchdog_off: assert property (
		wd_trip |=> spk_disable [*2])
		else $error("watchdog did not disable speaker");
	a_flag_after_done: assert property (
		$rose(spk_flag) |-> $past(spk_off_done) && spk_disable)
		else $error("shutdown flag before driver stop");
	a_switch_mode: assert property (
		(sw_mode == GSO_SW_OPEN) ##1 (sw_mode == GSO_SW_OPEN) |-> !switch_close)
		else $error("switch closed in open mode");
	a_read_switch: assert property (
		reg_rd && reg_addr == `GSO_REG_SWITCH && !wr_sw
		|=> reg_rdata == 16'($past(sw_mode)))
		else $error("switch mode readback wrong");
	a_lock_rise_event: assert property (
		$rose(asrc_lock[0]) |=> status[`GSO_EV_ASRC])
		else $error("lock rise not latched");
	a_fifo_event: assert property (
		$rose(fifo_not_empty[0]) |=> status[`GSO_EV_FIFO])
		else $error("FIFO event not latched");

	c_shutdown_done: cover property ($rose(spk_flag));
	c_irq_raised: cover property ($rose(irq));
	c_restart: cover property (spk_flag ##1 !spk_disable);
	c_clamp_close: cover property (sw_mode == GSO_SW_CLAMP_ON && switch_close);
endmodule // gso_status_out
`default_nettype wire

/* common/gso_defines.svh */
// Constants for the GPIO status output selector: offsets, codes, layouts.
// Assumes word addressing on a 16-bit register port.
`ifndef GSO_DEFINES_SVH
`define GSO_DEFINES_SVH
// Register word addresses
`define GSO_REG_SWITCH 16'h02c8
`define GSO_REG_FN_BASE 16'h1700
`define GSO_REG_PWM_CTRL 16'h1740
`define GSO_REG_PWM0_DUTY 16'h1741
`define GSO_REG_PWM1_DUTY 16'h1742
`define GSO_REG_SPDIF_CTRL 16'h1743
`define GSO_REG_SPDIF_CS_LO 16'h1744
`define GSO_REG_SPDIF_CS_HI 16'h1745
`define GSO_REG_SPK_CTRL 16'h1746
`define GSO_REG_RAW_A 16'h1748
`define GSO_REG_RAW_B 16'h1749
`define GSO_REG_STAT_A 16'h174a
`define GSO_REG_STAT_B 16'h174b
`define GSO_REG_MASK_A 16'h174c
`define GSO_REG_MASK_B 16'h174d
// Field positions
`define GSO_SW_MODE 1:0
`define GSO_PWM_SRC 1:0
`define GSO_VALID 1:0
`define GSO_SPK_WD_EN 0
`define GSO_SPK_WD_SEL 3:1
`define GSO_SPK_RESTART 4
// Pin function codes and group sizes
`define GSO_FN_W 9
`define GSO_FN_PWM 9'h048
`define GSO_FN_SPDIF 9'h04c
`define GSO_FN_ASRC 9'h088
`define GSO_FN_WARN 9'h0b6
`define GSO_FN_TSD 9'h0b7
`define GSO_FN_SHORT 9'h0e0
`define GSO_FN_SPKSD 9'h0e2
`define GSO_FN_TIMER 9'h140
`define GSO_FN_FIFO 9'h150
`define GSO_N_PWM 9'h002
`define GSO_N_ASRC 9'h004
`define GSO_N_SHORT 9'h002
`define GSO_N_TIMER 9'h008
`define GSO_N_FIFO 9'h008
// Flag and event vector layout
`define GSO_EV_W 25
`define GSO_EVA_W 9
`define GSO_EVB_W 16
`define GSO_EV_ASRC 0
`define GSO_EV_WARN 4
`define GSO_EV_TSD 5
`define GSO_EV_SHORT 6
`define GSO_EV_SPKSD 8
`define GSO_EV_TIMER 9
`define GSO_EV_FIFO 17
`define GSO_EV_BOTH 25'h000000f
`endif

/* common/gso_pkg.sv */
// Types shared by the GPIO status output selector.
// Assumes nothing beyond the defines header.
`default_nettype none
package gso_pkg;
	// Analogue switch mode field values
	typedef enum logic [1:0] {GSO_SW_OPEN = 2'b00, GSO_SW_CLOSED = 2'b01,
		GSO_SW_CLAMP_ON = 2'b10, GSO_SW_CLAMP_OFF = 2'b11} gso_sw_mode_e;
	// Speaker protection sequence
	typedef enum logic [1:0] {GSO_SPK_RUN = 2'b00, GSO_SPK_STOP = 2'b01,
		GSO_SPK_OFF = 2'b10} gso_spk_state_e;
endpackage
`default_nettype wire

/* common/gso_evt_if.sv */
// Status flag levels and their edge events, shared inside the block.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "gso_defines.svh"
interface gso_evt_if;
	logic [`GSO_EV_W-1:0] level; // Current flag levels
	logic [`GSO_EV_W-1:0] pulse; // One-cycle edge events
	modport ctl (output level, input pulse);
	modport det (input level, output pulse);
	modport sel (input level);
endinterface
`default_nettype wire

/* src/gso_edge_events.sv */
// Edge detector turning status flag levels into one-cycle events.
// Assumes flags are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "gso_defines.svh"
module gso_edge_events (
	input wire logic sys_clk,
	input wire logic rst_b,
	gso_evt_if.det ev
);
	logic [`GSO_EV_W-1:0] prev; // Flag levels one cycle ago
	// Remember last levels
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) prev <= '0;
		else prev <= ev.level;
	end
	// lock flags fire on both edges
	assign ev.pulse = (ev.level & ~prev) | (`GSO_EV_BOTH & prev & ~ev.level);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_lock_fall_event: assert property (
		$fell(ev.level[`GSO_EV_ASRC]) |-> ev.pulse[`GSO_EV_ASRC])
		else $error("lock flag fall gave no event");
endmodule // gso_edge_events
`default_nettype wire

/* src/gso_pin_select.sv */
// Per-pin source selection by function code, registered outputs.
// Assumes codes are held stable by the register file.
`timescale 1ns/1ps
`default_nettype none
`include "gso_defines.svh"
module gso_pin_select #(parameter int NUM_PINS = 40) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [NUM_PINS*`GSO_FN_W-1:0] fn_flat,
	input wire logic [1:0] pwm_wave,
	input wire logic spdif_tx,
	gso_evt_if.sel ev,
	output logic [NUM_PINS-1:0] gpio_out,
	output logic [NUM_PINS-1:0] gpio_src_valid
);
	logic [NUM_PINS-1:0] sel_val; // Chosen source level per pin
	logic [NUM_PINS-1:0] sel_hit; // Code names a source
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		wire [8:0] c = fn_flat[i*`GSO_FN_W +: `GSO_FN_W];
		wire [8:0] dp = c - `GSO_FN_PWM;
		wire [8:0] da = c - `GSO_FN_ASRC;
		wire [8:0] ds = c - `GSO_FN_SHORT;
		wire [8:0] dt = c - `GSO_FN_TIMER;
		wire [8:0] df = c - `GSO_FN_FIFO;
		wire hp = dp < `GSO_N_PWM;
		wire ha = da < `GSO_N_ASRC;
		wire hs = ds < `GSO_N_SHORT;
		wire ht = dt < `GSO_N_TIMER;
		wire hf = df < `GSO_N_FIFO;
		wire h_sp = c == `GSO_FN_SPDIF;
		wire h_w = c == `GSO_FN_WARN;
		wire h_t = c == `GSO_FN_TSD;
		wire h_k = c == `GSO_FN_SPKSD;
		assign sel_hit[i] = hp | ha | hs | ht | hf | h_sp | h_w | h_t | h_k;
		// group and single sources muxed onto the pin
		assign sel_val[i] = (hp & pwm_wave[dp[0]]) | (h_sp & spdif_tx)
			| (ha & ev.level[`GSO_EV_ASRC + da[1:0]])
			| (h_w & ev.level[`GSO_EV_WARN]) | (h_t & ev.level[`GSO_EV_TSD])
			| (hs & ev.level[`GSO_EV_SHORT + ds[0]])
			| (h_k & ev.level[`GSO_EV_SPKSD])
			| (ht & ev.level[`GSO_EV_TIMER + dt[2:0]])
			| (hf & ev.level[`GSO_EV_FIFO + df[2:0]]);
	end
	// Register pin drive
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			gpio_out <= '0;
			gpio_src_valid <= '0;
		end else begin
			gpio_out <= sel_val;
			gpio_src_valid <= sel_hit;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_unlisted_quiet: assert property (
		!sel_hit[0] |=> !gpio_out[0] && !gpio_src_valid[0])
		else $error("unlisted code drove pin");
endmodule // gso_pin_select
`default_nettype wire

/* testbench/gso_spk_model.sv */
// Speaker driver stand-in: reports stop done after a set delay.
// Assumes spk_disable comes from the block on the same clock.
`timescale 1ns/1ps
`default_nettype none
module gso_spk_model (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic spk_disable,
	input wire logic [7:0] stop_delay,
	output logic spk_off_done
);
	logic [7:0] cnt; // Cycles since disable rose
	// Done rises after the delay, drops once the block releases
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 8'h00;
			spk_off_done <= 1'b0;
		end else if (!spk_disable) begin
			cnt <= 8'h00;
			spk_off_done <= 1'b0;
		end else begin
			if (cnt != 8'hff) cnt <= cnt + 8'h01;
			spk_off_done <= (cnt >= stop_delay);
		end
	end
endmodule // gso_spk_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the status output selector.
// Assumes the speaker model stands in for the class D driver.
`timescale 1ns/1ps
`default_nettype none
`include "gso_defines.svh"
module testbench;
	import gso_pkg::*;
	localparam int NP = 40; // Pins served
	logic sys_clk; // 20 MHz clock
	logic rst_b; // Active-low reset
	logic [15:0] reg_addr, reg_wdata, reg_rdata; // Register port
	logic reg_wr, reg_rd; // Strobes
	logic [26:0] src; // Packed flag sources
	logic acc_det; // Clamp status
	logic [7:0] stop_delay; // Driver stop latency
	logic spk_off_done, irq, spk_disable, switch_close;
	logic [NP-1:0] gpio_out, gpio_src_valid;
	logic [1:0] pwm_duty_sel, spdif_validity;
	logic [15:0] pwm0_duty, pwm1_duty;
	logic [31:0] spdif_chan_status;
	int errors, checks_done, cycles;

	gso_status_out #(.NUM_PINS(NP)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_wave(src[1:0]),
		.spdif_tx(src[2]), .asrc_lock(src[6:3]), .temp_warn(src[7]),
		.temp_shutdown(src[8]), .spk_short(src[10:9]),
		.spk_off_done(spk_off_done), .timer_final(src[18:11]),
		.fifo_not_empty(src[26:19]), .accessory_detect(acc_det),
		.gpio_out(gpio_out), .gpio_src_valid(gpio_src_valid), .irq(irq),
		.spk_disable(spk_disable), .switch_close(switch_close),
		.pwm_duty_sel(pwm_duty_sel), .pwm0_duty(pwm0_duty),
		.pwm1_duty(pwm1_duty), .spdif_validity(spdif_validity),
		.spdif_chan_status(spdif_chan_status));
	gso_spk_model spk (.sys_clk(sys_clk), .rst_b(rst_b),
		.spk_disable(spk_disable), .stop_delay(stop_delay),
		.spk_off_done(spk_off_done));

	// Clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 5000) begin
			errors++;
			summarize();
		end
	end

	task automatic summarize();
		if (errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Compare a register-sized value
	task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Compare a single output level
	task automatic chk_pin(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read strobe, data taken in the following cycle
	task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk_reg(reg_rdata, exp);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic setsrc(input logic [26:0] v);
		@(posedge sys_clk);
		src <= v;
	endtask
	// Function code of each packed source bit
	function automatic logic [8:0] fn_of(input int i);
		if (i < 2) return `GSO_FN_PWM + 9'(i);
		if (i == 2) return `GSO_FN_SPDIF;
		if (i < 7) return `GSO_FN_ASRC + 9'(i - 3);
		if (i == 7) return `GSO_FN_WARN;
		if (i == 8) return `GSO_FN_TSD;
		if (i < 11) return `GSO_FN_SHORT + 9'(i - 9);
		if (i < 19) return `GSO_FN_TIMER + 9'(i - 11);
		return `GSO_FN_FIFO + 9'(i - 19);
	endfunction

	// Main sequence
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, src, acc_det} = '0;
		stop_delay = 8'h02;
		rst_b = 1'b0;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		rdc(`GSO_REG_SWITCH, 16'h0000); // reset open
		wr(`GSO_REG_SWITCH, 16'hffff);
		rdc(`GSO_REG_SWITCH, 16'h0003); // field only
		// Duty and transmitter settings
		wr(`GSO_REG_PWM_CTRL, 16'h0002);
		wr(`GSO_REG_PWM0_DUTY, 16'h1234);
		wr(`GSO_REG_PWM1_DUTY, 16'hbeef);
		wr(`GSO_REG_SPDIF_CTRL, 16'h0001);
		wr(`GSO_REG_SPDIF_CS_LO, 16'h5a5a);
		wr(`GSO_REG_SPDIF_CS_HI, 16'ha5c3);
		rdc(`GSO_REG_PWM1_DUTY, 16'hbeef); // duty readback
		rdc(`GSO_REG_SPDIF_CS_HI, 16'ha5c3); // status readback
		chk_reg({14'h0, pwm_duty_sel}, 16'h0002); // source choice
		chk_reg(pwm0_duty, 16'h1234); // fixed duty
		chk_reg(pwm1_duty, 16'hbeef); // second fixed duty
		chk_reg({14'h0, spdif_validity}, 16'h0001); // validity
		chk_reg(spdif_chan_status[31:16], 16'ha5c3); // upper word
		chk_reg(spdif_chan_status[15:0], 16'h5a5a); // lower word
		wr(16'h1747, 16'hffff);
		rdc(16'h1747, 16'h0000); // unmapped reads zero
		// Switch modes against clamp state
		for (int m = 0; m < 4; m++) begin
			wr(`GSO_REG_SWITCH, 16'(m));
			for (int a = 0; a < 2; a++) begin
				@(posedge sys_clk);
				acc_det <= a[0];
				settle(2);
				chk_pin(switch_close, 1'(m == 1 || (m == 2 && a == 1) ||
					(m == 3 && a == 0))); // mode table
			end
		end
		// Every packed source bit on its own pin (not the shutdown flag), the next pin stays low
		for (int i = 0; i < 27; i++) wr(`GSO_REG_FN_BASE + 16'(i), 16'(fn_of(i)));
		rdc(`GSO_REG_FN_BASE + 16'h0005, 16'h008a); // code readback
		for (int i = 0; i < 27; i++) begin
			setsrc(27'h1 << i);
			settle(2);
			chk_pin(gpio_out[i], 1'b1); // pin high
			chk_pin(gpio_src_valid[i], 1'b1); // code recognised
			chk_pin(gpio_out[(i + 1) % 27], 1'b0); // other pin low
			setsrc(27'h0);
			settle(2);
			chk_pin(gpio_out[i], 1'b0); // pin follows source
		end
		// Unlisted codes and upper bits of a code
		wr(`GSO_REG_FN_BASE + 16'h001e, 16'h004a);
		wr(`GSO_REG_FN_BASE + 16'h001f, 16'h01ff);
		wr(`GSO_REG_FN_BASE + 16'h0021, 16'hfe48);
		wr(`GSO_REG_FN_BASE + 16'h001b, 16'(`GSO_FN_SPKSD));
		rdc(`GSO_REG_FN_BASE + 16'h0021, 16'h0048); // code field only
		setsrc(27'h7ffffff);
		settle(2);
		chk_pin(gpio_out[30] | gpio_src_valid[30], 1'b0); // no source
		chk_pin(gpio_out[31] | gpio_src_valid[31], 1'b0); // no source
		chk_pin(gpio_src_valid[32], 1'b0); // reset code
		chk_pin(gpio_out[33], 1'b1); // masked code still pwm
		setsrc(27'h0);
		settle(4);
		wr(`GSO_REG_SPK_CTRL, 16'h0010);
		settle(2);
		chk_pin(spk_disable, 1'b0); // restart when cool
		// Lock flag edges, stickiness and masking
		wr(`GSO_REG_STAT_A, 16'hffff);
		wr(`GSO_REG_STAT_B, 16'hffff);
		rdc(`GSO_REG_STAT_B, 16'h0000); // cleared by ones
		setsrc(27'h10);
		settle(2);
		rdc(`GSO_REG_RAW_A, 16'h0002); // raw level
		rdc(`GSO_REG_STAT_A, 16'h0002); // rising edge
		wr(`GSO_REG_STAT_A, 16'h0002);
		rdc(`GSO_REG_STAT_A, 16'h0000); // clear by one
		setsrc(27'h0);
		settle(2);
		rdc(`GSO_REG_STAT_A, 16'h0002); // falling edge
		wr(`GSO_REG_MASK_A, 16'h0002);
		settle(2);
		chk_pin(irq, 1'b1); // unmasked drives irq
		wr(`GSO_REG_MASK_A, 16'h0000);
		settle(2);
		chk_pin(irq, 1'b0); // masked quiet
		rdc(`GSO_REG_STAT_A, 16'h0002); // still latched
		wr(`GSO_REG_MASK_A, 16'h0002);
		wr(`GSO_REG_STAT_A, 16'hffff);
		settle(2);
		chk_pin(irq, 1'b0); // irq drops after clear
		// Warning flag raises on its rise only
		setsrc(27'h80);
		settle(2);
		rdc(`GSO_REG_STAT_A, 16'h0010); // rising edge
		wr(`GSO_REG_STAT_A, 16'hffff);
		setsrc(27'h0);
		settle(2);
		rdc(`GSO_REG_STAT_A, 16'h0000); // fall ignored
		// Timer pulse and logger not-empty
		setsrc(27'h1 << 13);
		setsrc(27'h1 << 24);
		settle(2);
		rdc(`GSO_REG_STAT_B, 16'h2004); // both events
		rdc(`GSO_REG_RAW_B, 16'h2000); // level still high
		wr(`GSO_REG_MASK_B, 16'h0004);
		settle(2);
		chk_pin(irq, 1'b1); // timer event to irq
		// Overheat shutdown with a slow driver
		stop_delay <= 8'h14;
		wr(`GSO_REG_MASK_A, 16'h0100);
		setsrc(27'h100);
		settle(2);
		chk_pin(spk_disable, 1'b1); // overheat disables
		chk_pin(gpio_out[27], 1'b0); // no flag before stop
		rdc(`GSO_REG_RAW_A, 16'h0020); // flag still low
		settle(25);
		chk_pin(gpio_out[27], 1'b1); // flag after stop
		rdc(`GSO_REG_STAT_A, 16'h0120); // flag events
		wr(`GSO_REG_SPK_CTRL, 16'h0010);
		settle(2);
		chk_pin(spk_disable, 1'b1); // no restart while hot
		setsrc(27'h0);
		wr(`GSO_REG_SPK_CTRL, 16'h0010);
		settle(2);
		chk_pin(spk_disable, 1'b0); // restart when cool
		// Speaker short with a prompt driver
		stop_delay <= 8'h00;
		setsrc(27'h400);
		settle(2);
		chk_pin(spk_disable, 1'b1); // short disables
		setsrc(27'h0);
		settle(4);
		wr(`GSO_REG_SPK_CTRL, 16'h0010);
		// Timer watchdog, off then on
		setsrc(27'h1 << 14);
		setsrc(27'h0);
		settle(2);
		chk_pin(spk_disable, 1'b0); // watchdog off ignores
		wr(`GSO_REG_SPK_CTRL, 16'h0007);
		rdc(`GSO_REG_SPK_CTRL, 16'h0007); // control readback
		setsrc(27'h1 << 14);
		setsrc(27'h0);
		settle(2);
		chk_pin(spk_disable, 1'b1); // expiry shuts down
		settle(4);
		wr(`GSO_REG_SPK_CTRL, 16'h0010);
		settle(2);
		chk_pin(spk_disable, 1'b0); // restart clears
		summarize();
	end
endmodule // testbench
`default_nettype wire
